// >>> pkg/fcs_cfg.svh
// Purpose: Offsets, field positions, reset values and timing of the flash command sequencer
// Assumes: Byte offsets on a 32-bit classic Wishbone bus
// Notes:   Definitions only
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

// Register byte offsets
`define FCS_OFF_STAT 8'h00
`define FCS_OFF_CMD  8'h04
`define FCS_OFF_ADDR 8'h08
`define FCS_OFF_DATA 8'h0C
`define FCS_OFF_PAGE 8'h10
`define FCS_OFF_PROT 8'h14
`define FCS_OFF_SEC  8'h18
`define FCS_OFF_ISTS 8'h1C
`define FCS_OFF_IMSK 8'h20

// Status register bits
`define FCS_STAT_CBE 7
`define FCS_STAT_CC  6
`define FCS_STAT_PV  5
`define FCS_STAT_ACC 4

// Block protection register fields
`define FCS_PROT_OPEN   7
`define FCS_PROT_HDIS   5
`define FCS_PROT_HS_MSB 4
`define FCS_PROT_HS_LSB 3
`define FCS_PROT_LDIS   2
`define FCS_PROT_LS_MSB 1
`define FCS_PROT_LS_LSB 0

// Interrupt status and mask bits
`define FCS_IRQ_CBE 0
`define FCS_IRQ_CC  1
`define FCS_IRQ_ACC 2
`define FCS_IRQ_PV  3

// Reset values
`define FCS_PROT_RST 8'hFF
`define FCS_SEC_RST  8'hFF
`define FCS_PAGE_RST 6'h00
`define FCS_CMD_RST  8'h00

// Logical map
`define FCS_ARR_LO   16'h4000
`define FCS_WIN_LO   16'h8000
`define FCS_WIN_HI   16'hBFFF
`define FCS_PAGE_BOT 6'h3E
`define FCS_PAGE_TOP 6'h3F

// Configuration field
`define FCS_KEY_ADDR  16'hFF00
`define FCS_KEY_BYTES 8
`define FCS_PROT_ADDR 16'hFF0D
`define FCS_SEC_ADDR  16'hFF0F

// Protection areas in physical space
`define FCS_LO_BASE 20'hF8000
`define FCS_ARR_END 20'hFFFFF
`define FCS_LO_UNIT 20'h00200
`define FCS_HI_UNIT 20'h00800

// Command codes
`define FCS_CMD_VERIFY 8'h05
`define FCS_CMD_PROG   8'h20
`define FCS_CMD_SERASE 8'h40
`define FCS_CMD_MERASE 8'h41

// Timing
`define FCS_CLK_NS     5
`define FCS_OP_TIME_NS 100

`endif

// >>> pkg/fcs_pkg.sv
// Purpose: Types of the flash command sequencer
// Assumes: One-hot state codes
// Notes:   Constants live in fcs_cfg.svh
`default_nettype none
package fcs_pkg;
    typedef enum logic [2:0] {
        FCS_SEQ_IDLE = 3'b001,
        FCS_SEQ_ADDR = 3'b010,
        FCS_SEQ_CMD  = 3'b100
    } fcs_seq_t;

    typedef enum logic [2:0] {
        FCS_LD_PROT = 3'b001,
        FCS_LD_SEC  = 3'b010,
        FCS_LD_DONE = 3'b100
    } fcs_ld_t;

    typedef enum logic [1:0] {
        FCS_EX_IDLE = 2'b01,
        FCS_EX_RUN  = 2'b10
    } fcs_ex_t;
endpackage : fcs_pkg
`default_nettype wire

// >>> pkg/fcs_exec_if.sv
// Purpose: Hand-off of one buffered command to the executor
// Assumes: Single clock domain
// Notes:   start is a one-cycle pulse, done marks the last busy cycle
`timescale 1ns/1ps
`default_nettype none
interface fcs_exec_if ();
    logic        start;
    logic [7:0]  cmd;
    logic [19:0] addr;
    logic [15:0] data;
    logic        busy;
    logic        done;

    modport seq (output start, output cmd, output addr, output data, input busy, input done);
    modport exe (input start, input cmd, input addr, input data, output busy, output done);
endinterface : fcs_exec_if
`default_nettype wire

// >>> hw/fcs_exec.sv
// Purpose: Runs one flash operation for a fixed number of cycles
// Assumes: start only while not busy
// Notes:   Drives the array operation outputs from flip-flops
`include "fcs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fcs_exec #(
    parameter int unsigned OP_CYCLES = (`FCS_OP_TIME_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    fcs_exec_if.exe          ex,
    output logic             op_valid_o,
    output logic [7:0]       op_cmd_o,
    output logic [19:0]      op_addr_o,
    output logic [15:0]      op_data_o
);
    fcs_pkg::fcs_ex_t state;
    fcs_pkg::fcs_ex_t next_state;
    logic [15:0]      cnt;
    logic [15:0]      next_cnt;
    logic             next_valid;
    logic [7:0]       next_cmd;
    logic [19:0]      next_addr;
    logic [15:0]      next_data;

    assign ex.busy = (state == fcs_pkg::FCS_EX_RUN);
    assign ex.done = ex.busy && (cnt == 16'h0000);

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_valid = op_valid_o;
        next_cmd   = op_cmd_o;
        next_addr  = op_addr_o;
        next_data  = op_data_o;
        unique case (state)
            fcs_pkg::FCS_EX_IDLE: begin
                if (ex.start) begin
                    next_state = fcs_pkg::FCS_EX_RUN;
                    next_cnt   = 16'(OP_CYCLES - 1);
                    next_valid = 1'b1;
                    next_cmd   = ex.cmd;
                    next_addr  = ex.addr;
                    next_data  = ex.data;
                end
            end
            fcs_pkg::FCS_EX_RUN: begin
                if (cnt == 16'h0000) begin
                    next_state = fcs_pkg::FCS_EX_IDLE;
                    next_valid = 1'b0;
                end else begin
                    next_cnt = cnt - 16'h0001;
                end
            end
            default: begin
                next_state = fcs_pkg::FCS_EX_IDLE;
                next_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state      <= fcs_pkg::FCS_EX_IDLE;
            cnt        <= 16'h0000;
            op_valid_o <= 1'b0;
            op_cmd_o   <= 8'h00;
            op_addr_o  <= 20'h00000;
            op_data_o  <= 16'h0000;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            op_valid_o <= next_valid;
            op_cmd_o   <= next_cmd;
            op_addr_o  <= next_addr;
            op_data_o  <= next_data;
        end
    end
endmodule : fcs_exec
`default_nettype wire

// >>> hw/fcs_top.sv
// Purpose: Flash command sequencer with paged array window and protection
// Assumes: Classic Wishbone slave, array read data valid in the same cycle
// Notes:   Configuration bytes are read from the array after reset
//
// Chosen here: register access over Wishbone and the register addresses.
`include "fcs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Check buffer empty; new load overwrites buffers
// - Capture written address and data
// - Launch clears command complete flag
// - Buffer empty sets after complete cleared
// - Buffered command waits for active one
// - Complete sets after all commands finish
// - Array at 0x4000-0xFFFF, window paged
// - Pages 0x3E, 0x3F map fixed pages
// - Configuration field key, protection, security bytes
// - Global and lower/higher/remaining area protection
// - Protection register loaded during reset; here loaded in the first cycle after reset is released
module fcs_top #(
    parameter int unsigned OP_CYCLES = (`FCS_OP_TIME_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic [17:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [19:0]      arr_addr_o,
    input  wire logic [15:0] arr_rdata_i,
    output logic             op_valid_o,
    output logic [7:0]       op_cmd_o,
    output logic [19:0]      op_addr_o,
    output logic [15:0]      op_data_o,
    output logic             irq_o
);
    fcs_exec_if ex ();

    fcs_pkg::fcs_seq_t seq;
    fcs_pkg::fcs_seq_t next_seq;
    fcs_pkg::fcs_ld_t  ld;
    fcs_pkg::fcs_ld_t  next_ld;
    logic              cbe, next_cbe, cc, next_cc, acc, next_acc, pv, next_pv;
    logic [7:0]        cmd_buf, next_cmd_buf, prot, next_prot, sec, next_sec, stat_v;
    logic [15:0]       addr_log, next_addr_log, data_buf, next_data_buf;
    logic [19:0]       addr_phy, next_addr_phy;
    logic [5:0]        page, next_page;
    logic [3:0]        ists, next_ists, imsk, next_imsk, ev;
    logic              next_ack;
    logic [31:0]       next_rdat;
    logic [15:0]       log_a;
    logic              req, wr, is_arr, is_reg, flags;
    logic              wr_arr, wr_stat, wr_cmd, wr_page, wr_prot, wr_ists, wr_imsk, mod_wr;
    logic              step1, step2, step3, abort, pv_hit, launch;

    function automatic logic [19:0] fcs_map(input logic [15:0] a, input logic [5:0] pg);
        logic [5:0] p;
        p = `FCS_PAGE_TOP;
        if (a >= `FCS_ARR_LO && a < `FCS_WIN_LO) p = `FCS_PAGE_BOT;
        else if (a >= `FCS_WIN_LO && a <= `FCS_WIN_HI) p = pg;
        return {p, a[13:0]};
    endfunction : fcs_map

    function automatic logic fcs_prot_hit(input logic [19:0] a, input logic [7:0] p);
        logic [19:0] hi_sz;
        logic [19:0] lo_sz;
        logic        in_area;
        hi_sz   = `FCS_HI_UNIT << p[`FCS_PROT_HS_MSB:`FCS_PROT_HS_LSB];
        lo_sz   = `FCS_LO_UNIT << p[`FCS_PROT_LS_MSB:`FCS_PROT_LS_LSB];
        in_area = (!p[`FCS_PROT_HDIS] && a > `FCS_ARR_END - hi_sz) ||
                  (!p[`FCS_PROT_LDIS] && a >= `FCS_LO_BASE && a < `FCS_LO_BASE + lo_sz);
        // Open: areas protected; closed: everything but the areas
        return p[`FCS_PROT_OPEN] ? in_area : !in_area;
    endfunction : fcs_prot_hit

    function automatic logic fcs_cmd_ok(input logic [7:0] c);
        return c == `FCS_CMD_VERIFY || c == `FCS_CMD_PROG || c == `FCS_CMD_SERASE || c == `FCS_CMD_MERASE;
    endfunction : fcs_cmd_ok

    // Bus decode
    assign log_a   = {wb_adr_i[16:2], 1'b0};
    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o && (ld == fcs_pkg::FCS_LD_DONE);
    assign wr      = req && wb_we_i && wb_sel_i[0];
    assign is_arr  = wb_adr_i[17];
    assign is_reg  = !wb_adr_i[17] && (wb_adr_i[16:8] == 9'h000);
    assign wr_arr  = wr && is_arr;
    assign wr_stat = wr && is_reg && wb_adr_i[7:0] == `FCS_OFF_STAT;
    assign wr_cmd  = wr && is_reg && wb_adr_i[7:0] == `FCS_OFF_CMD;
    assign wr_page = wr && is_reg && wb_adr_i[7:0] == `FCS_OFF_PAGE;
    assign wr_prot = wr && is_reg && wb_adr_i[7:0] == `FCS_OFF_PROT;
    assign wr_ists = wr && is_reg && wb_adr_i[7:0] == `FCS_OFF_ISTS;
    assign wr_imsk = wr && is_reg && wb_adr_i[7:0] == `FCS_OFF_IMSK;
    // Interrupt registers stand outside the load sequence
    assign mod_wr  = wr && (is_arr || is_reg) && !wr_ists && !wr_imsk;
    assign flags   = acc || pv;

    // Load sequence steps
    assign step1  = wr_arr && seq == fcs_pkg::FCS_SEQ_IDLE && !flags && log_a >= `FCS_ARR_LO;
    assign step2  = wr_cmd && seq == fcs_pkg::FCS_SEQ_ADDR && fcs_cmd_ok(wb_dat_i[7:0]);
    assign step3  = wr_stat && wb_dat_i[`FCS_STAT_CBE] && seq == fcs_pkg::FCS_SEQ_CMD;
    assign abort  = (seq != fcs_pkg::FCS_SEQ_IDLE && mod_wr && !step2 && !step3) ||
                    (seq == fcs_pkg::FCS_SEQ_IDLE && (wr_cmd || (wr_stat && wb_dat_i[`FCS_STAT_CBE]) ||
                     (wr_arr && !flags && log_a < `FCS_ARR_LO)));
    assign pv_hit = (cmd_buf == `FCS_CMD_PROG || cmd_buf == `FCS_CMD_SERASE) ? fcs_prot_hit(addr_phy, prot) :
                    (cmd_buf == `FCS_CMD_MERASE) && (!prot[`FCS_PROT_OPEN] ||
                     !prot[`FCS_PROT_HDIS] || !prot[`FCS_PROT_LDIS]);
    assign launch = step3 && !pv_hit;

    // Pending command moves to the executor once it is idle
    assign ex.start = !cbe && !ex.busy && !step3;
    assign ex.cmd   = cmd_buf;
    assign ex.addr  = addr_phy;
    assign ex.data  = data_buf;

    assign arr_addr_o = (ld == fcs_pkg::FCS_LD_PROT) ? fcs_map(`FCS_PROT_ADDR & 16'hFFFE, page) :
                        (ld == fcs_pkg::FCS_LD_SEC)  ? fcs_map(`FCS_SEC_ADDR & 16'hFFFE, page) :
                        fcs_map(log_a, page);
    assign irq_o = |(ists & imsk);

    always_comb begin
        stat_v = 8'h00;
        stat_v[`FCS_STAT_CBE] = cbe;
        stat_v[`FCS_STAT_CC]  = cc;
        stat_v[`FCS_STAT_PV]  = pv;
        stat_v[`FCS_STAT_ACC] = acc;
    end

    always_comb begin
        next_ack      = req;
        next_rdat     = wb_dat_o;
        next_seq      = seq;
        next_ld       = ld;
        next_cbe      = cbe;
        next_cc       = cc;
        next_acc      = acc;
        next_pv       = pv;
        next_cmd_buf  = cmd_buf;
        next_addr_log = addr_log;
        next_addr_phy = addr_phy;
        next_data_buf = data_buf;
        next_page     = page;
        next_prot     = prot;
        next_sec      = sec;
        next_imsk     = imsk;
        ev            = 4'h0;

        // Configuration bytes: odd addresses sit in the low byte
        unique case (ld)
            fcs_pkg::FCS_LD_PROT: begin
                next_prot = arr_rdata_i[7:0];
                next_ld   = fcs_pkg::FCS_LD_SEC;
            end
            fcs_pkg::FCS_LD_SEC: begin
                next_sec = arr_rdata_i[7:0];
                next_ld  = fcs_pkg::FCS_LD_DONE;
            end
            fcs_pkg::FCS_LD_DONE: begin
            end
        endcase

        if (req && !wb_we_i) begin
            next_rdat = 32'h00000000;
            if (is_arr) begin
                next_rdat = {16'h0000, arr_rdata_i};
            end else if (is_reg) begin
                unique case (wb_adr_i[7:0])
                    `FCS_OFF_STAT: next_rdat = {24'h000000, stat_v};
                    `FCS_OFF_CMD:  next_rdat = {24'h000000, cmd_buf};
                    `FCS_OFF_ADDR: next_rdat = {12'h000, addr_phy};
                    `FCS_OFF_DATA: next_rdat = {16'h0000, data_buf};
                    `FCS_OFF_PAGE: next_rdat = {26'h0, page};
                    `FCS_OFF_PROT: next_rdat = {24'h000000, prot};
                    `FCS_OFF_SEC:  next_rdat = {24'h000000, sec};
                    `FCS_OFF_ISTS: next_rdat = {28'h0000000, ists};
                    `FCS_OFF_IMSK: next_rdat = {28'h0000000, imsk};
                    default:       next_rdat = 32'h00000000;
                endcase
            end
        end

        if (wr_page) next_page = wb_dat_i[5:0];
        if (wr_imsk) next_imsk = wb_dat_i[3:0];
        if (wr_prot) begin
            next_prot[`FCS_PROT_OPEN] = prot[`FCS_PROT_OPEN] && wb_dat_i[`FCS_PROT_OPEN];
            next_prot[`FCS_PROT_HDIS] = prot[`FCS_PROT_HDIS] && wb_dat_i[`FCS_PROT_HDIS];
            next_prot[`FCS_PROT_LDIS] = prot[`FCS_PROT_LDIS] && wb_dat_i[`FCS_PROT_LDIS];
            if (prot[`FCS_PROT_HDIS])
                next_prot[`FCS_PROT_HS_MSB:`FCS_PROT_HS_LSB] = wb_dat_i[`FCS_PROT_HS_MSB:`FCS_PROT_HS_LSB];
            if (prot[`FCS_PROT_LDIS])
                next_prot[`FCS_PROT_LS_MSB:`FCS_PROT_LS_LSB] = wb_dat_i[`FCS_PROT_LS_MSB:`FCS_PROT_LS_LSB];
        end

        // Error flags: write one to clear, a new error wins
        if (wr_stat) begin
            if (wb_dat_i[`FCS_STAT_ACC]) next_acc = 1'b0;
            if (wb_dat_i[`FCS_STAT_PV])  next_pv  = 1'b0;
        end

        // Load sequence; a load while a command is pending overwrites it
        unique case (seq)
            fcs_pkg::FCS_SEQ_IDLE: begin
                if (step1) begin
                    next_addr_log = log_a;
                    next_addr_phy = fcs_map(log_a, page);
                    next_data_buf = wb_dat_i[15:0];
                    next_seq      = fcs_pkg::FCS_SEQ_ADDR;
                end
            end
            fcs_pkg::FCS_SEQ_ADDR: begin
                if (step2) begin
                    next_cmd_buf = wb_dat_i[7:0];
                    next_seq     = fcs_pkg::FCS_SEQ_CMD;
                end
            end
            fcs_pkg::FCS_SEQ_CMD: begin
                if (step3) next_seq = fcs_pkg::FCS_SEQ_IDLE;
            end
            default: next_seq = fcs_pkg::FCS_SEQ_IDLE;
        endcase
        if (abort) begin
            next_seq = fcs_pkg::FCS_SEQ_IDLE;
            next_acc = 1'b1;
        end
        if (step3 && pv_hit) next_pv = 1'b1;

        if (ex.start) next_cbe = 1'b1;
        if (ex.done && cbe) next_cc = 1'b1;
        if (launch) begin
            next_cbe = 1'b0;
            next_cc  = 1'b0;
        end

        ev[`FCS_IRQ_CBE] = next_cbe && !cbe;
        ev[`FCS_IRQ_CC]  = next_cc && !cc;
        ev[`FCS_IRQ_ACC] = next_acc && !acc;
        ev[`FCS_IRQ_PV]  = next_pv && !pv;
        next_ists = (ists & ~(wr_ists ? wb_dat_i[3:0] : 4'h0)) | ev;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            seq      <= fcs_pkg::FCS_SEQ_IDLE;
            ld       <= fcs_pkg::FCS_LD_PROT;
            cbe      <= 1'b1;
            cc       <= 1'b1;
            acc      <= 1'b0;
            pv       <= 1'b0;
            cmd_buf  <= `FCS_CMD_RST;
            addr_log <= 16'h0000;
            addr_phy <= 20'h00000;
            data_buf <= 16'h0000;
            page     <= `FCS_PAGE_RST;
            prot     <= `FCS_PROT_RST;
            sec      <= `FCS_SEC_RST;
            ists     <= 4'h0;
            imsk     <= 4'h0;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_rdat;
            seq      <= next_seq;
            ld       <= next_ld;
            cbe      <= next_cbe;
            cc       <= next_cc;
            acc      <= next_acc;
            pv       <= next_pv;
            cmd_buf  <= next_cmd_buf;
            addr_log <= next_addr_log;
            addr_phy <= next_addr_phy;
            data_buf <= next_data_buf;
            page     <= next_page;
            prot     <= next_prot;
            sec      <= next_sec;
            ists     <= next_ists;
            imsk     <= next_imsk;
        end
    end

    fcs_exec #(
        .OP_CYCLES (OP_CYCLES)
    ) u_exec (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .ex         (ex),
        .op_valid_o (op_valid_o),
        .op_cmd_o   (op_cmd_o),
        .op_addr_o  (op_addr_o),
        .op_data_o  (op_data_o)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    AST_CAPTURE: assert property (step1 |=> addr_log == $past(log_a) && data_buf == $past(wb_dat_i[15:0]))
        else $error("Address or data not captured");
    AST_LAUNCH_CC: assert property (launch |=> !cc && !cbe ##1 !cc)
        else $error("Launch did not clear complete flag");
    AST_CBE_RISE: assert property ($rose(cbe) |-> !cc && $past(ex.start))
        else $error("Buffer empty set while complete flag high");
    AST_WAIT_ACTIVE: assert property (ex.busy && !ex.done
                                      |=> ex.busy && op_cmd_o == $past(op_cmd_o) && op_addr_o == $past(op_addr_o))
        else $error("Active operation disturbed before finishing");
    AST_CC_ALL_DONE: assert property ($rose(cc) |-> cbe && $past(ex.done) && !ex.busy)
        else $error("Complete flag set with work outstanding");
    AST_WINDOW: assert property (ld == fcs_pkg::FCS_LD_DONE && log_a >= `FCS_WIN_LO && log_a <= `FCS_WIN_HI
                                 |-> arr_addr_o == {page, log_a[13:0]})
        else $error("Window not mapped through page select");
    AST_FIXED_TOP: assert property (ld == fcs_pkg::FCS_LD_DONE && log_a > `FCS_WIN_HI
                                    |-> arr_addr_o[19:14] == `FCS_PAGE_TOP)
        else $error("Top fixed page mapped wrongly");
    AST_PROT_LOAD: assert property (ld == fcs_pkg::FCS_LD_PROT && !srst_i
                                    |=> prot == $past(arr_rdata_i[7:0]))
        else $error("Protection byte not loaded at reset");
    AST_PROTECTION_VIOLATION_FLAG: assert property (step3 && pv_hit |=> pv && cbe == $past(cbe) && seq == fcs_pkg::FCS_SEQ_IDLE)
        else $error("Protected launch not refused");
    AST_ABORT: assert property (abort |=> acc && seq == fcs_pkg::FCS_SEQ_IDLE)
        else $error("Broken sequence not flagged");
endmodule : fcs_top
`default_nettype wire

// >>> sim/fcs_array_model.sv
// Purpose: Flash array contents seen by the sequencer
// Assumes: Word read of the addressed location in the same cycle
// Notes:   Configuration words give the loaded protection and security bytes
`timescale 1ns/1ps
`default_nettype none
module fcs_array_model (
    input  wire logic [19:0] addr_i,
    output logic [15:0]      rdata_o
);
    always_comb begin
        rdata_o = addr_i[15:0] ^ 16'h5A5A;
        if (addr_i == 20'hFFF0C) begin
            rdata_o = 16'hA5BF;
        end else if (addr_i == 20'hFFF0E) begin
            rdata_o = 16'hA57E;
        end
    end
endmodule : fcs_array_model
`default_nettype wire

// >>> sim/fcs_tb_top.sv
// Purpose: Self-checking bench of the flash command sequencer
// Assumes: Array model answers in the same cycle
// Notes:   Operation time of 48 cycles, above the default of 20, keeps a second command buffered
`include "fcs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fcs_tb_top;
    localparam int unsigned OPC = 48;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [17:0] adr = '0;
    logic [31:0] wdat = '0;
    logic        we = 1'b0;
    logic        cyc = 1'b0;
    logic [31:0] rd_q, dat_o;
    logic        ack, op_valid, irq;
    logic [19:0] arr_addr, seen_arr, op_addr;
    logic [15:0] arr_rdata, op_data;
    logic [7:0]  op_cmd;
    int          bad_count = 0;
    int          check_count = 0;
    always #2.5 clk_i = ~clk_i;
    fcs_top #(.OP_CYCLES(OPC)) i_dut (.clk_i(clk_i), .srst_i(srst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .arr_addr_o(arr_addr), .arr_rdata_i(arr_rdata), .op_valid_o(op_valid), .op_cmd_o(op_cmd),
        .op_addr_o(op_addr), .op_data_o(op_data), .irq_o(irq));
    fcs_array_model i_arr (.addr_i(arr_addr), .rdata_o(arr_rdata));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [17:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd_q = dat_o;
        seen_arr = arr_addr;
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    function automatic logic [17:0] ra(input logic [7:0] off);
        return {10'h000, off};
    endfunction : ra
    function automatic logic [17:0] aa(input logic [15:0] l);
        return {1'b1, l[15:1], 2'b00};
    endfunction : aa
    task automatic rchk(input logic [7:0] off, input logic [31:0] exp);
        wb(1'b0, ra(off), 32'h0);
        chk(rd_q, exp);
    endtask : rchk
    task automatic load(input logic [15:0] la, input logic [15:0] d, input logic [7:0] c);
        wb(1'b1, aa(la), {16'h0, d});
        wb(1'b1, ra(`FCS_OFF_CMD), {24'h0, c});
        wb(1'b1, ra(`FCS_OFF_STAT), 32'h80);
    endtask : load
    task automatic t_reset();
        rchk(`FCS_OFF_STAT, 32'hC0);
        rchk(`FCS_OFF_PROT, 32'hBF);
        rchk(`FCS_OFF_SEC, 32'h7E);
        rchk(8'h30, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_map();
        logic [5:0] pg [3] = '{6'h3E, 6'h3F, 6'h05};
        foreach (pg[i]) begin
            wb(1'b1, ra(`FCS_OFF_PAGE), {26'h0, pg[i]});
            wb(1'b0, aa(16'h8002), 32'h0);
            chk(seen_arr, {pg[i], 14'h0002});
        end
        wb(1'b0, aa(16'h4004), 32'h0);
        chk(seen_arr, {6'h3E, 14'h0004});
        wb(1'b0, aa(16'hC006), 32'h0);
        chk(seen_arr, {6'h3F, 14'h0006});
        $display("map test done");
    endtask : t_map
    task automatic t_launch();
        int n;
        n = 0;
        load(16'hC010, 16'h1234, `FCS_CMD_PROG);
        rchk(`FCS_OFF_STAT, 32'h80);
        rchk(`FCS_OFF_ADDR, 32'hFC010);
        rchk(`FCS_OFF_DATA, 32'h1234);
        chk({op_valid, op_cmd, op_addr, op_data}, {1'b1, `FCS_CMD_PROG, 20'hFC010, 16'h1234});
        load(16'h8002, 16'h0055, `FCS_CMD_VERIFY);
        rchk(`FCS_OFF_STAT, 32'h00);
        load(16'h4006, 16'h00AA, `FCS_CMD_VERIFY);
        rchk(`FCS_OFF_STAT, 32'h00);
        chk(op_cmd, `FCS_CMD_PROG);
        while (!(op_valid === 1'b1 && op_cmd !== `FCS_CMD_PROG) && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        chk({op_cmd, op_addr, op_data}, {`FCS_CMD_VERIFY, 20'hF8006, 16'h00AA});
        rchk(`FCS_OFF_STAT, 32'h80);
        do begin
            wb(1'b0, ra(`FCS_OFF_STAT), 32'h0);
            n++;
        end while (rd_q[6] !== 1'b1 && n < 300);
        chk({rd_q, op_valid}, {32'hC0, 1'b0});
        $display("launch test done");
    endtask : t_launch
    task automatic t_abort();
        wb(1'b1, ra(`FCS_OFF_CMD), 32'h20);
        rchk(`FCS_OFF_STAT, 32'hD0);
        chk(irq, 1'b0);
        wb(1'b1, ra(`FCS_OFF_IMSK), 32'h4);
        chk(irq, 1'b1);
        wb(1'b1, ra(`FCS_OFF_ISTS), 32'h4);
        chk(irq, 1'b0);
        wb(1'b1, ra(`FCS_OFF_STAT), 32'h10);
        rchk(`FCS_OFF_STAT, 32'hC0);
        wb(1'b1, aa(16'hC020), 32'h0077);
        wb(1'b1, ra(`FCS_OFF_PAGE), 32'h3);
        wb(1'b1, ra(`FCS_OFF_STAT), 32'h80);
        rchk(`FCS_OFF_STAT, 32'hD0);
        chk(op_valid, 1'b0);
        $display("abort test done");
    endtask : t_abort
    task automatic t_protect();
        wb(1'b1, ra(`FCS_OFF_STAT), 32'h10);
        wb(1'b1, ra(`FCS_OFF_PROT), 32'h3F);
        rchk(`FCS_OFF_PROT, 32'h3F);
        load(16'hC030, 16'h0011, `FCS_CMD_SERASE);
        rchk(`FCS_OFF_STAT, 32'hE0);
        wb(1'b1, ra(`FCS_OFF_STAT), 32'h20);
        load(16'h4000, 16'h0000, `FCS_CMD_MERASE);
        rchk(`FCS_OFF_STAT, 32'hE0);
        chk(op_valid, 1'b0);
        $display("protect test done");
    endtask : t_protect
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_map();
        t_launch();
        t_abort();
        t_protect();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        end_of_test();
    end
endmodule : fcs_tb_top
`default_nettype wire
